// [hw/sdwl_top.sv]
/*
  Serial write latch: receives 16-bit words on chip select, serial clock and
  serial data, holds them in an input register, and moves them to the output
  register on the active-low load strobe.
  Assumes all serial pins and the strobe are asynchronous to clk_in and that
  the serial clock is well below half of clk_in.
*/
`timescale 1ns/10ps
module sdwl_top
  import sdwl_pkg::*;
#(
  parameter int unsigned CODE_WIDTH = 12
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic chip_select_n_in,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic load_output_strobe_n_in,
  output logic vref_buffer_enable_out,
  output logic gain_select_n_out,
  output logic active_not_shutdown_out,
  output logic [CODE_WIDTH-1:0] code_bits_out
);

  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [1:0] cs_sync_q;
  logic [1:0] sck_sync_q;
  logic [1:0] sdi_sync_q;
  logic [1:0] ld_sync_q;
  logic cs_n_s;
  logic sck_s;
  logic sdi_s;
  logic ld_n_s;
  logic cs_prev_q;
  logic sck_prev_q;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Idle levels: chip select high, strobe high
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_q <= 2'h3;
      sck_sync_q <= 2'h0;
      sdi_sync_q <= 2'h0;
      ld_sync_q <= 2'h3;
      cs_prev_q <= 1'b1;
      sck_prev_q <= 1'b0;
    end else begin
      cs_sync_q <= {cs_sync_q[0], chip_select_n_in};
      sck_sync_q <= {sck_sync_q[0], serial_clock_in};
      sdi_sync_q <= {sdi_sync_q[0], serial_data_in};
      ld_sync_q <= {ld_sync_q[0], load_output_strobe_n_in};
      cs_prev_q <= cs_sync_q[1];
      sck_prev_q <= sck_sync_q[1];
    end
  end
  assign cs_n_s = cs_sync_q[1];
  assign sck_s = sck_sync_q[1];
  assign sdi_s = sdi_sync_q[1];
  assign ld_n_s = ld_sync_q[1];

  // ----------------------------------------
  // Shift logic
  // ----------------------------------------
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic shift_en;
  logic frame_ok;
  logic word_accept;
  logic [SDWL_WORD_BITS-1:0] shift_q;
  logic [SDWL_CNT_BITS-1:0] count_q;

  assign cs_fall = cs_prev_q && !cs_n_s;
  assign cs_rise = !cs_prev_q && cs_n_s;
  assign sck_rise = !sck_prev_q && sck_s;
  // Mode 0,0 and 1,1 both sample data at the rising edge
  assign shift_en = !cs_n_s && sck_rise && (count_q < SDWL_FULL_COUNT);
  assign frame_ok = (count_q == SDWL_FULL_COUNT);
  assign word_accept = cs_rise && frame_ok && !shift_q[SDWL_IGNORE_BIT];

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= SDWL_WORD_RESET;
      count_q <= '0;
    end else if (cs_fall) begin
      count_q <= '0;
    end else if (shift_en) begin
      shift_q <= {shift_q[SDWL_WORD_BITS-2:0], sdi_s};
      count_q <= count_q + 5'h01;
    end
  end

  // ----------------------------------------
  // Input and output registers
  // ----------------------------------------
  logic in_vref_q;
  logic in_gain_n_q;
  logic in_active_q;
  logic [CODE_WIDTH-1:0] in_code_q;
  logic in_valid_q;
  logic load_now;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      in_vref_q <= SDWL_VREF_BUF_RESET;
      in_gain_n_q <= SDWL_GAIN_N_RESET;
      in_active_q <= SDWL_ACTIVE_RESET;
      in_code_q <= '0;
      in_valid_q <= 1'b0;
    end else if (word_accept) begin
      in_vref_q <= shift_q[SDWL_VREF_BUF_BIT];
      in_gain_n_q <= shift_q[SDWL_GAIN_BIT];
      in_active_q <= shift_q[SDWL_ACTIVE_BIT];
      in_code_q <= shift_q[SDWL_CODE_MSB -: CODE_WIDTH];
      in_valid_q <= 1'b1;
    end
  end

  // A held-low strobe follows each new latch one cycle later
  assign load_now = !ld_n_s && in_valid_q;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      vref_buffer_enable_out <= SDWL_VREF_BUF_RESET;
      gain_select_n_out <= SDWL_GAIN_N_RESET;
      active_not_shutdown_out <= SDWL_ACTIVE_RESET;
      code_bits_out <= '0;
    end else if (load_now) begin
      vref_buffer_enable_out <= in_vref_q;
      gain_select_n_out <= in_gain_n_q;
      active_not_shutdown_out <= in_active_q;
      code_bits_out <= in_code_q;
    end
  end
  // No serial output port exists.

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_tail_ignored: assert property (@(posedge clk_in) disable iff (!rst_n)
    (count_q == SDWL_FULL_COUNT) && !cs_fall |=> $stable(shift_q))
    else $error("shift after sixteenth clock");
  a_idle_no_shift: assert property (@(posedge clk_in) disable iff (!rst_n)
    cs_n_s && !cs_fall |=> $stable(shift_q))
    else $error("shift while chip select high");
  a_short_abort: assert property (@(posedge clk_in) disable iff (!rst_n)
    cs_rise && (count_q != SDWL_FULL_COUNT) |=> $stable(in_code_q) && $stable(in_active_q))
    else $error("short frame changed input register");
  a_ignore_cmd: assert property (@(posedge clk_in) disable iff (!rst_n)
    cs_rise && shift_q[SDWL_IGNORE_BIT] |=> $stable(in_valid_q) && $stable(in_code_q))
    else $error("ignored command changed register");
  a_capture_word: assert property (@(posedge clk_in) disable iff (!rst_n)
    word_accept |=> in_code_q == $past(shift_q[SDWL_CODE_MSB -: CODE_WIDTH])
      && in_active_q == $past(shift_q[SDWL_ACTIVE_BIT]))
    else $error("word not captured");
  a_held_load: assert property (@(posedge clk_in) disable iff (!rst_n)
    word_accept && !ld_n_s ##1 !ld_n_s |=> code_bits_out == $past(in_code_q, 1))
    else $error("held strobe did not update output");
  a_strobe_high: assert property (@(posedge clk_in) disable iff (!rst_n)
    ld_n_s |=> $stable(code_bits_out) && $stable(active_not_shutdown_out))
    else $error("output changed without strobe");
  a_stay_shut: assert property (@(posedge clk_in) disable iff (!rst_n)
    !active_not_shutdown_out && !in_active_q |=> !active_not_shutdown_out)
    else $error("left shutdown without active bit");
  a_count_clear: assert property (@(posedge clk_in) disable iff (!rst_n)
    cs_fall |=> count_q == '0)
    else $error("counter not cleared on frame start");
  a_count_range: assert property (@(posedge clk_in) disable iff (!rst_n)
    count_q <= SDWL_FULL_COUNT)
    else $error("bit counter passed sixteen");
  a_cfg_capture: assert property (@(posedge clk_in) disable iff (!rst_n)
    word_accept |=> in_vref_q == $past(shift_q[SDWL_VREF_BUF_BIT])
      && in_gain_n_q == $past(shift_q[SDWL_GAIN_BIT]))
    else $error("configuration bits not captured");
  // Output follows the input register one cycle after the synced strobe
  a_load_copy: assert property (@(posedge clk_in) disable iff (!rst_n)
    load_now |=> code_bits_out == $past(in_code_q)
      && vref_buffer_enable_out == $past(in_vref_q)
      && gain_select_n_out == $past(in_gain_n_q)
      && active_not_shutdown_out == $past(in_active_q))
    else $error("strobe did not copy input register");
  // A strobe before any valid word must not wake the output
  a_early_shut: assert property (@(posedge clk_in) disable iff (!rst_n)
    !in_valid_q |=> !active_not_shutdown_out && $stable(code_bits_out))
    else $error("output woke before a valid write");

  c_full_frame: cover property (@(posedge clk_in) disable iff (!rst_n) word_accept);
  c_short_frame: cover property (@(posedge clk_in) disable iff (!rst_n) cs_rise && !frame_ok);
  c_wake: cover property (@(posedge clk_in) disable iff (!rst_n) $rose(active_not_shutdown_out));
  c_held_load: cover property (@(posedge clk_in) disable iff (!rst_n) word_accept && !ld_n_s);
  c_ignored_cmd: cover property (@(posedge clk_in) disable iff (!rst_n)
    cs_rise && frame_ok && shift_q[SDWL_IGNORE_BIT]);

endmodule : sdwl_top

// [common/sdwl_pkg.sv]
/*
  Constants for the serial write latch of a single-channel voltage DAC.
  Assumes a single system clock domain; the serial pins are sampled into it.
*/
package sdwl_pkg;
  localparam int unsigned SDWL_WORD_BITS = 16;
  localparam int unsigned SDWL_CNT_BITS = 5;
  localparam logic [4:0] SDWL_FULL_COUNT = 5'h10;
  localparam int unsigned SDWL_IGNORE_BIT = 15;
  localparam int unsigned SDWL_VREF_BUF_BIT = 14;
  localparam int unsigned SDWL_GAIN_BIT = 13;
  localparam int unsigned SDWL_ACTIVE_BIT = 12;
  localparam int unsigned SDWL_CODE_MSB = 11;
  localparam int unsigned SDWL_CODE_BITS = 12;
  localparam logic [15:0] SDWL_WORD_RESET = 16'h0000;
  localparam logic SDWL_VREF_BUF_RESET = 1'b0;
  localparam logic SDWL_GAIN_N_RESET = 1'b0;
  localparam logic SDWL_ACTIVE_RESET = 1'b0;
  localparam logic [11:0] SDWL_CODE_RESET = 12'h000;
endpackage : sdwl_pkg

// [tb/sdwl_host.sv]
/*
  Host model: serial master and load strobe driver.
  Assumes bench clock clk_in; serial clock half period is 4 cycles.
*/
`timescale 1ns/10ps
module sdwl_host (
  input wire logic clk_in,
  output logic chip_select_n_out,
  output logic serial_clock_out,
  output logic serial_data_out,
  output logic load_output_strobe_n_out
);
  // -----
  // Drive
  // -----
  initial begin
    chip_select_n_out = 1'b1;
    serial_clock_out = 1'b0;
    serial_data_out = 1'b0;
    load_output_strobe_n_out = 1'b1;
  end
  // Data keeps moving between frames so a leaky shifter shows
  always @(negedge clk_in) begin
    if (chip_select_n_out) begin
      serial_data_out <= ~serial_data_out;
    end
  end
  // Bits past sixteen are inverted, so taking them corrupts the word
  // Mode 0,0 idles low and mode 1,1 idles high; both take bits on the rising edge
  task automatic send(input logic [15:0] word_in, input int clocks_in, input logic idle_in);
    int i;
    @(negedge clk_in) chip_select_n_out <= 1'b0;
    for (i = 0; i < clocks_in; i++) begin
      repeat (4) @(negedge clk_in);
      serial_clock_out <= 1'b0;
      serial_data_out <= word_in[(15 - i) & 15] ^ (i > 15);
      repeat (4) @(negedge clk_in);
      serial_clock_out <= 1'b1;
    end
    repeat (4) @(negedge clk_in);
    serial_clock_out <= idle_in;
    chip_select_n_out <= 1'b1;
    repeat (4) @(negedge clk_in);
  endtask : send
  task automatic pulse_load();
    @(negedge clk_in) load_output_strobe_n_out <= 1'b0;
    repeat (4) @(negedge clk_in);
    load_output_strobe_n_out <= 1'b1;
  endtask : pulse_load
  task automatic hold_load();
    @(negedge clk_in) load_output_strobe_n_out <= 1'b0;
  endtask : hold_load
  // Clock edges with chip select high must not reach the shifter
  task automatic stray_clocks(input int pulses_in);
    int j;
    for (j = 0; j < pulses_in; j++) begin
      repeat (4) @(negedge clk_in);
      serial_clock_out <= ~serial_clock_out;
      repeat (4) @(negedge clk_in);
      serial_clock_out <= ~serial_clock_out;
    end
    repeat (4) @(negedge clk_in);
  endtask : stray_clocks
endmodule : sdwl_host

// [tb/tb.sv]
/*
  Bench: random, short and long frames, ignored words, pulsed then held strobe.
  Assumes the host model and the default code width of 12.
*/
`timescale 1ns/10ps
module tb
  import sdwl_pkg::*;
;
  logic clk, reset_n, cs_n, sck, sdi, ld_n, vref, gain_n, active;
  logic [11:0] code;
  logic [15:0] w, exp_in_q, exp_out_q, seen_w;
  int seed, miscompares, total_checks, n, k;
  int lens[4] = '{16, 16, 11, 19};
  assign seen_w = {1'b0, vref, gain_n, active, code};
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  sdwl_top uut (.clk_in(clk), .reset_n_in(reset_n), .chip_select_n_in(cs_n),
    .serial_clock_in(sck), .serial_data_in(sdi), .load_output_strobe_n_in(ld_n),
    .vref_buffer_enable_out(vref), .gain_select_n_out(gain_n),
    .active_not_shutdown_out(active), .code_bits_out(code));
  sdwl_host host (.clk_in(clk), .chip_select_n_out(cs_n), .serial_clock_out(sck),
    .serial_data_out(sdi), .load_output_strobe_n_out(ld_n));
  // ------
  // Checks
  // ------
  function automatic logic [15:0] latch(input logic [15:0] old, input logic [15:0] wd,
    input int c);
    if (c >= SDWL_WORD_BITS && wd[SDWL_IGNORE_BIT] === 1'b0) return wd;
    return old;
  endfunction : latch
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    total_checks++;
    if (seen !== expv) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  // Hang guard, about four times the expected run
  initial begin
    #1000000;
    miscompares++;
    end_sim();
  end
  initial begin
    seed = 32'hfc9e_6576;
    reset_n = 1'b0;
    exp_in_q = SDWL_WORD_RESET;
    exp_out_q = SDWL_WORD_RESET;
    repeat (8) @(posedge clk);
    @(negedge clk) reset_n <= 1'b1;
    repeat (4) @(negedge clk);
    check(seen_w, 16'h0000);
    host.pulse_load();
    repeat (6) @(negedge clk);
    check(seen_w, 16'h0000);
    for (n = 0; n < 40; n++) begin
      w = 16'($random(seed));
      k = (n < 3) ? 16 : lens[$random(seed) & 3];
      if (n < 3) w[15] = 1'b0;
      if (n == 20) host.hold_load();
      if (n % 5 == 4) host.stray_clocks(3);
      host.send(w, k, 1'($random(seed)));
      exp_in_q = latch(exp_in_q, w, k);
      if (n < 20) begin
        check(seen_w, {1'b0, exp_out_q[14:0]});
        host.pulse_load();
      end
      repeat (6) @(negedge clk);
      exp_out_q = exp_in_q;
      check(seen_w, {1'b0, exp_out_q[14:0]});
    end
    // Mid-run reset with the strobe still held low: no wake before a valid word
    @(negedge clk) reset_n <= 1'b0;
    repeat (2) @(negedge clk);
    check(seen_w, 16'h0000);
    reset_n <= 1'b1;
    repeat (8) @(negedge clk);
    check(seen_w, 16'h0000);
    w = 16'($random(seed)) | 16'h1000;
    w[15] = 1'b0;
    host.send(w, 16, 1'b0);
    repeat (6) @(negedge clk);
    check(seen_w, w);
    end_sim();
  end
endmodule : tb
